// >>> hdl/gst_pkg.sv
// Purpose: shared constants and carriers for the GPIB status, timer and
//          bus-line register bank
// Assumes: byte-wide register port, one 10 MHz device clock
// Notes:   aux command codes and register offsets live only here
package gst_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_DATA = 4'h0; // r: data-in, w: data_out_latch
    localparam logic [3:0] OFS_INT_STATUS_0 = 4'h1;
    localparam logic [3:0] OFS_INT_STATUS_1 = 4'h2;
    localparam logic [3:0] OFS_INT_STATUS_2 = 4'h3;
    localparam logic [3:0] OFS_PASS_THROUGH_COMMAND_REG = 4'h4; // r: pass_through_command_reg
    localparam logic [3:0] OFS_LINE = 4'h6; // r: line_sense, w: line_drive
    localparam logic [3:0] OFS_CCMD = 4'h7; // w: carry_command
    localparam logic [3:0] OFS_CFG = 4'h8; // w: config bits below
    localparam logic [3:0] OFS_AUX = 4'ha; // w: aux_command_port

    // config register fields
    localparam int CFG_CARRY_CYCLE_ENABLE = 0; // carry_cycle_enable
    localparam int CFG_BTO = 1; // byte_timeout_select
    localparam int CFG_ONECHIP = 2; // one-chip mode
    localparam logic [7:0] CFG_RESET = 8'h00;

    // ------------------------------------------------------------------
    // aux commands (upper nibble selects aux register writes)
    // ------------------------------------------------------------------
    localparam logic [7:0] AUX_CHIP_RESET = 8'h02;
    localparam logic [7:0] AUX_VALID = 8'h0f;
    localparam logic [7:0] AUX_NONVALID = 8'h07;
    localparam logic [2:0] AUX_CLR_HI = 3'h2; // 010b_iiiii: clear bit i
    localparam logic [3:0] AUX_REGI_HI = 4'he; // bit0: static_status_mode
    localparam logic [3:0] AUX_TSEL_HI = 4'hf; // low nibble: timeout_code

    // ------------------------------------------------------------------
    // status bit positions in the flat 24-bit status vector
    // ------------------------------------------------------------------
    localparam int ST_W = 24;
    localparam int B_SYNC = 0;
    localparam int B_STATUS_BYTE_OUT_FLAG = 1;
    localparam int B_TO = 2;
    localparam int B_DI = 8;
    localparam int B_DO = 9;
    localparam int B_ERR = 10;
    localparam int B_DEC = 11;
    localparam int B_END = 12;
    localparam int B_DET = 13;
    localparam int B_APT = 14;
    localparam int B_CPT = 15;
    localparam int B_ADDRESS_STATUS_CHANGE_FLAG = 16;
    localparam int B_REMOTE_CHANGE_FLAG = 17;
    localparam int B_LOCKOUT_CHANGE_FLAG = 18;
    localparam int B_ATN = 19;
    localparam int B_IFC = 20;
    // bits whose clearing ignores static_status_mode
    localparam logic [ST_W-1:0] ST_EXEMPT = 24'h000007;

    // ------------------------------------------------------------------
    // timer
    // ------------------------------------------------------------------
    localparam int TMO_W = 33;
    localparam logic [TMO_W-1:0] TMO_MULT = 33'h000000005;
    localparam logic [3:0] TMO_OFF = 4'h0;

    function automatic logic [4:0] tmo_factor(input logic [3:0] code);
        unique case (code)
            4'h1: tmo_factor = 5'd7;
            4'h2: tmo_factor = 5'd8;
            4'h3: tmo_factor = 5'd10;
            4'h4: tmo_factor = 5'd11;
            4'h5: tmo_factor = 5'd13;
            4'h6: tmo_factor = 5'd15;
            4'h7: tmo_factor = 5'd17;
            4'h8: tmo_factor = 5'd18;
            4'h9: tmo_factor = 5'd20;
            4'ha: tmo_factor = 5'd21;
            4'hb: tmo_factor = 5'd23;
            4'hc: tmo_factor = 5'd25;
            4'hd: tmo_factor = 5'd27;
            4'he: tmo_factor = 5'd28;
            4'hf: tmo_factor = 5'd30;
            default: tmo_factor = 5'd0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    // one-cycle event pulses from the interface-function engine
    typedef struct packed {
        logic sync;
        logic status_byte_out_flag;
        logic data_in; // byte latched, data on i_din
        logic data_out_rdy;
        logic err;
        logic dclr;
        logic end_rx;
        logic trig;
        logic address_pass_through_flag;
        logic command_pass_through_flag; // command latched, byte on i_cmd
        logic address_status_change_flag;
        logic remote_change_flag;
        logic lockout_change_flag;
        logic atn;
        logic ifc;
    } gst_evt_t;

    // state levels and pulses used by the clear conditions, the timer restart and the carry cycle
    typedef struct packed {
        logic tacs; // level: talker active
        logic sgns; // level: source generate
        logic ton_lon; // pulse: entry to talk-only or listen-only
        logic hs_done; // pulse: handshake finished
        logic holdoff; // level: holdoff mode active
        logic byte_moved; // pulse: byte moved fifo <-> gpib
        logic nba_clr; // pulse: source handshake took the byte
        logic last_byte; // pulse: last byte about to move fifo <-> regs
    } gst_state_t;

endpackage

// >>> hdl/gst_regs.sv
// Purpose: GPIB status flags, timeout timer, bus-line access, carry cycle
//          and data-out latch behind a byte-wide register port
// Assumes: engine events are synchronous one-cycle pulses
// Notes:   gpib lines are low-true open drain
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module gst_regs #(
    parameter logic [3:0] TMO_CUT = gst_pkg::TMO_OFF // shortens intervals
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // interface-function engine
    input wire gst_pkg::gst_evt_t i_evt,
    input wire gst_pkg::gst_state_t i_st,
    input wire logic [7:0] i_din,
    input wire logic [7:0] i_cmd,
    output logic o_nba,
    output logic o_aux_exec,
    output logic [7:0] o_aux_code,
    // gpib pins
    input wire logic [7:0] i_line,
    output logic [7:0] o_line,
    output logic [7:0] o_line_oe,
    output logic [7:0] o_dio,
    output logic o_dio_oe
);
    import gst_pkg::*;

    // ------------------------------------------------------------------
    // decode and aux command path
    // ------------------------------------------------------------------
    logic wr_data, rd_data, wr_line, wr_ccmd, wr_cfg, wr_aux, carry_go;
    logic pon, tsel_wr, clr_cmd, cfg_carry_cycle_enable, cfg_bto, cfg_one;
    logic [7:0] cfg_r, carry_cmd_r, din_r, dout_r, cmd_r, drive_r, rdata_r;
    logic [7:0] aux_code;
    logic aux_exec, static_r, nba_r;

    // strobes for each register
    assign wr_data = i_wr && i_addr == OFS_DATA;
    assign rd_data = i_rd && i_addr == OFS_DATA;
    assign wr_line = i_wr && i_addr == OFS_LINE;
    assign wr_ccmd = i_wr && i_addr == OFS_CCMD;
    assign wr_cfg = i_wr && i_addr == OFS_CFG;
    assign wr_aux = i_wr && i_addr == OFS_AUX;
    assign cfg_carry_cycle_enable = cfg_r[CFG_CARRY_CYCLE_ENABLE];
    assign cfg_bto = cfg_r[CFG_BTO];
    assign cfg_one = cfg_r[CFG_ONECHIP];

    // carry cycle takes the aux port; a host aux write that same cycle
    // is dropped, software never overlaps it with a running transfer
    assign carry_go = i_st.last_byte && cfg_carry_cycle_enable && !cfg_one;
    assign aux_exec = carry_go || wr_aux;
    assign aux_code = carry_go ? carry_cmd_r : i_wdata;
    assign o_aux_exec = aux_exec;
    assign o_aux_code = aux_code;

    // power-on covers hardware reset and the chip reset command
    assign pon = i_rst || (aux_exec && aux_code == AUX_CHIP_RESET);
    assign tsel_wr = aux_exec && aux_code[7:4] == AUX_TSEL_HI;
    assign clr_cmd = aux_exec && aux_code[7:5] == AUX_CLR_HI;

    // configuration bits
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cfg_r <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= i_wdata;
        end
    end

    // carry command holds its content through any reset
    always_ff @(posedge i_core_clk) begin
        if (wr_ccmd) begin
            carry_cmd_r <= i_wdata;
        end
    end

    // static mode bit lives in aux register I
    always_ff @(posedge i_core_clk) begin
        if (pon) begin
            static_r <= 1'b0;
        end else if (aux_exec && aux_code[7:4] == AUX_REGI_HI) begin
            static_r <= aux_code[0];
        end
    end

    // ------------------------------------------------------------------
    // data registers and nba
    // ------------------------------------------------------------------
    // separate storage: reading data-in never touches data-out
    always_ff @(posedge i_core_clk) begin
        if (i_evt.data_in) begin
            din_r <= i_din;
        end
        if (i_evt.command_pass_through_flag) begin
            cmd_r <= i_cmd;
        end
        if (wr_data) begin
            dout_r <= i_wdata;
        end
    end

    // transparent during the write cycle, then holds the written byte
    assign o_dio = wr_data ? i_wdata : dout_r;
    assign o_dio_oe = i_st.tacs;

    // nba set by a data-out write; write wins over the handshake clear
    always_ff @(posedge i_core_clk) begin
        if (pon) begin
            nba_r <= 1'b0;
        end else if (wr_data) begin
            nba_r <= 1'b1;
        end else if (i_st.nba_clr) begin
            nba_r <= 1'b0;
        end
    end
    assign o_nba = nba_r;

    // ------------------------------------------------------------------
    // bus lines
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (pon) begin
            drive_r <= 8'h00;
        end else if (wr_line) begin
            drive_r <= i_wdata;
        end
    end
    // open drain: asserting a line pulls it low
    assign o_line = 8'h00;
    assign o_line_oe = drive_r;

    // ------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------
    logic [ST_W-1:0] st_r, set_v, rdclr_v, sclr_v, fixclr_v, to_set;
    logic nba_rise, nba_d_r, to_fixclr;

    always_ff @(posedge i_core_clk) begin
        nba_d_r <= nba_r;
    end
    assign nba_rise = nba_r && !nba_d_r;

    // event to flag mapping
    always_comb begin
        set_v = '0;
        set_v[B_SYNC] = i_evt.sync;
        set_v[B_STATUS_BYTE_OUT_FLAG] = i_evt.status_byte_out_flag;
        set_v[B_TO] = to_set[0];
        set_v[B_DI] = i_evt.data_in;
        set_v[B_DO] = i_evt.data_out_rdy;
        set_v[B_ERR] = i_evt.err;
        set_v[B_DEC] = i_evt.dclr;
        set_v[B_END] = i_evt.end_rx;
        set_v[B_DET] = i_evt.trig;
        set_v[B_APT] = i_evt.address_pass_through_flag;
        set_v[B_CPT] = i_evt.command_pass_through_flag;
        set_v[B_ADDRESS_STATUS_CHANGE_FLAG] = i_evt.address_status_change_flag;
        set_v[B_REMOTE_CHANGE_FLAG] = i_evt.remote_change_flag;
        set_v[B_LOCKOUT_CHANGE_FLAG] = i_evt.lockout_change_flag;
        set_v[B_ATN] = i_evt.atn;
        set_v[B_IFC] = i_evt.ifc;
    end

    // register reads that clear a whole status register
    always_comb begin
        rdclr_v = '0;
        rdclr_v[7:0] = {8{i_rd && i_addr == OFS_INT_STATUS_0}};
        rdclr_v[15:8] = {8{i_rd && i_addr == OFS_INT_STATUS_1}};
        rdclr_v[23:16] = {8{i_rd && i_addr == OFS_INT_STATUS_2}};
    end

    // static-mode clear conditions beyond power-on and own command
    always_comb begin
        sclr_v = '0;
        if (clr_cmd && aux_code[4:0] < 5'(ST_W)) begin
            sclr_v[aux_code[4:0]] = 1'b1;
        end
        if (i_st.ton_lon) begin
            sclr_v[B_ADDRESS_STATUS_CHANGE_FLAG] = 1'b1;
        end
        if (aux_exec && (aux_code == AUX_VALID ||
                aux_code == AUX_NONVALID)) begin
            sclr_v[B_APT] = 1'b1;
        end
        if (i_rd && i_addr == OFS_PASS_THROUGH_COMMAND_REG) begin
            sclr_v[B_CPT] = 1'b1;
        end
        if (rd_data || (i_st.hs_done && i_st.holdoff)) begin
            sclr_v[B_DI] = 1'b1;
        end
        if (!i_st.tacs || !i_st.sgns || nba_rise) begin
            sclr_v[B_DO] = 1'b1;
        end
    end

    // sync and status_byte_out_flag clear on read; in byte mode timeout waits for select
    assign to_fixclr = tsel_wr || (rdclr_v[B_TO] && !cfg_bto);
    always_comb begin
        fixclr_v = rdclr_v & ST_EXEMPT;
        fixclr_v[B_TO] = to_fixclr;
    end

    // one flop per flag; a set always beats a clear in the same cycle
    generate
        for (genvar b = 0; b < ST_W; b++) begin : g_flag
            logic clr;
            assign clr = ST_EXEMPT[b] ? fixclr_v[b] :
                (static_r ? sclr_v[b] : rdclr_v[b]);
            always_ff @(posedge i_core_clk) begin
                if (set_v[b]) begin
                    st_r[b] <= 1'b1;
                end else if (pon || clr) begin
                    st_r[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // timeout timer
    // ------------------------------------------------------------------
    logic [3:0] tcode_r;
    logic [TMO_W-1:0] tcnt_r, tlimit;
    logic [4:0] tfac;
    logic trun, trestart, tdone_r;

    // timeout select: reset, chip reset or a zero code stop the timer
    always_ff @(posedge i_core_clk) begin
        if (pon) begin
            tcode_r <= 4'h0;
        end else if (tsel_wr) begin
            tcode_r <= aux_code[3:0];
        end
    end

    // five times two to the factor; cut only shortens simulations
    assign tfac = tmo_factor(tcode_r) - 5'(TMO_CUT);
    assign tlimit = TMO_MULT << tfac;
    assign trun = tcode_r != 4'h0 && !tdone_r;
    assign trestart = cfg_bto && (rd_data || wr_data ||
        (cfg_one && i_st.byte_moved));
    assign to_set[0] = trun && !trestart && !tsel_wr &&
        tcnt_r == tlimit - 33'h000000001;
    assign to_set[ST_W-1:1] = '0;
    // expiry latches until the next select write: one run per write
    always_ff @(posedge i_core_clk) begin
        if (pon || tsel_wr) tdone_r <= 1'b0;
        else if (to_set[0]) tdone_r <= 1'b1;
    end

    // counter restarts on every select write and in byte mode on traffic
    always_ff @(posedge i_core_clk) begin
        if (pon || tsel_wr || trestart || !trun) begin
            tcnt_r <= '0;
        end else begin
            tcnt_r <= tcnt_r + 33'h000000001;
        end
    end

    // ------------------------------------------------------------------
    // read data, valid in the cycle after the read strobe
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rdata_r <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                OFS_DATA: rdata_r <= din_r;
                OFS_INT_STATUS_0: rdata_r <= st_r[7:0];
                OFS_INT_STATUS_1: rdata_r <= st_r[15:8];
                OFS_INT_STATUS_2: rdata_r <= st_r[23:16];
                OFS_PASS_THROUGH_COMMAND_REG: rdata_r <= cmd_r;
                OFS_LINE: rdata_r <= ~i_line;
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign o_rdata = rdata_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_tsel_zero;
        tsel_wr && aux_code[3:0] == 4'h0 && !pon;
    endsequence
    sequence s_stopped;
        tcnt_r == '0 ##1 tcnt_r == '0;
    endsequence

    a_read_clear: assert property (
        i_rd && i_addr == OFS_INT_STATUS_1 && !static_r && set_v[15:8] == 8'h00
        |=> st_r[15:8] == 8'h00)
        else $error("status read in normal mode did not clear");
    a_static_hold: assert property (
        i_rd && i_addr == OFS_INT_STATUS_2 && static_r && !pon && !aux_exec &&
        !i_st.ton_lon && set_v[23:16] == 8'h00
        |=> st_r[23:16] == $past(st_r[23:16]))
        else $error("status read in static mode changed flags");
    a_tmo_zero_stop: assert property (
        s_tsel_zero |=> s_stopped)
        else $error("zero timeout code did not stop timer");
    a_tmo_expire: assert property (
        trun && !trestart && !tsel_wr && !pon &&
        tcnt_r == tlimit - 33'h000000001 |=> st_r[B_TO])
        else $error("timeout flag missed at interval end");
    a_tsel_reset: assert property (
        aux_exec && aux_code == AUX_CHIP_RESET |=> tcode_r == 4'h0)
        else $error("chip reset left timeout select");
    a_byte_restart: assert property (
        cfg_bto && rd_data && trun && !pon |=> tcnt_r == '0)
        else $error("data read did not restart byte timer");
    a_to_sticky: assert property (
        cfg_bto && st_r[B_TO] && !tsel_wr && !pon
        |=> st_r[B_TO])
        else $error("byte-mode timeout flag dropped early");
    a_sense_read: assert property (
        i_rd && i_addr == OFS_LINE |=> o_rdata == ~$past(i_line))
        else $error("line sense read wrong");
    a_drive_write: assert property (
        wr_line && !pon |=> o_line_oe == $past(i_wdata))
        else $error("line drive not applied");
    a_carry_inject: assert property (
        i_st.last_byte && cfg_carry_cycle_enable && !cfg_one
        |-> o_aux_exec && o_aux_code == carry_cmd_r)
        else $error("carry cycle not injected");
    a_nba_set: assert property (
        wr_data && !pon |=> o_nba)
        else $error("data-out write did not set nba");
    a_dout_transp: assert property (
        wr_data |-> o_dio == i_wdata ##1 (wr_data || o_dio == $past(i_wdata)))
        else $error("data-out latch not transparent");

endmodule

// >>> verification/gst_bus_model.sv
// Purpose: far-side gpib bus, wired control lines with pull-ups
// Assumes: lines are low-true open drain, other devices pull on demand
// Notes:   purely combinational, no clock needed
`timescale 1ns/100ps
module gst_bus_model (
    // drive from the block and from other instruments
    input wire logic [7:0] i_pull_oe,
    input wire logic [7:0] i_ext_assert,
    // resolved wire level, atn at bit 7
    output logic [7:0] o_wire
);
    // -------------------------------------------------------------
    // wire resolution
    // -------------------------------------------------------------
    // any party pulling wins; released lines float high by pull-up
    assign o_wire = ~(i_pull_oe | i_ext_assert);
endmodule

// >>> verification/gst_regs_tb.sv
// Purpose: self-checking bench for the gpib status/timer register bank
// Assumes: TMO_CUT of 5, so code 1 expires 20 clocks after the write
// Notes:   host side driven by tasks, bus side by the line model
`timescale 1ns/100ps
module gst_regs_tb;
    import gst_pkg::*;
    // -------------------------------------------------------------
    // signals
    // -------------------------------------------------------------
    logic clk = 0, rst = 1, wr = 0, rd = 0;
    logic [3:0] addr = '0;
    logic [7:0] wdata = '0, din = '0, ext = '0, wire_lvl, rdata, oe;
    logic [7:0] aux_code, dio, line_v, cmd = '0;
    logic nba, aux_exec, dio_oe;
    gst_evt_t evt = '0;
    gst_state_t st = '0;
    int errors = 0, check_count = 0;
    gst_regs #(.TMO_CUT(4'h5)) gst_regs_inst (.i_core_clk(clk),
        .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_evt(evt), .i_st(st), .i_din(din),
        .i_cmd(cmd), .o_nba(nba), .o_aux_exec(aux_exec),
        .o_aux_code(aux_code), .i_line(wire_lvl), .o_line(line_v),
        .o_line_oe(oe), .o_dio(dio), .o_dio_oe(dio_oe));
    gst_bus_model gst_bus_model_inst (.i_pull_oe(oe), .i_ext_assert(ext),
        .o_wire(wire_lvl));
    // -------------------------------------------------------------
    // host access tasks
    // -------------------------------------------------------------
    initial forever #50 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // write, then a gap so the strobe is never set twice in one step
    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        addr <= a; wdata <= d; wr <= 1;
        @(posedge clk); wr <= 0;
        @(posedge clk);
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        addr <= a; rd <= 1;
        @(posedge clk); rd <= 0;
        @(negedge clk); chk(rdata, e);
        @(posedge clk);
    endtask
    task automatic pulse(input gst_evt_t e);
        evt <= e;
        @(posedge clk); evt <= '0;
        @(posedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles needed
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        finish_test();
    end
    // -------------------------------------------------------------
    // tests
    // -------------------------------------------------------------
    initial begin
        gst_evt_t e;
        st.tacs <= 1; st.sgns <= 1;
        repeat (8) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rdc(OFS_INT_STATUS_1, 8'h00); rdc(4'h5, 8'h00);
        // normal mode: a read empties the register; data-in preloaded
        din <= 8'h99; e = '0; e.err = 1; e.data_in = 1; pulse(e);
        rdc(OFS_INT_STATUS_1, 8'h05); rdc(OFS_INT_STATUS_1, 8'h00);
        $display("test read-clear done");
        // one-shot timer: once read away the flag stays clear until the next select write
        wrr(OFS_AUX, 8'hf1); repeat (12) @(posedge clk);
        rdc(OFS_INT_STATUS_0, 8'h00); repeat (6) @(posedge clk);
        rdc(OFS_INT_STATUS_0, 8'h04);
        repeat (30) @(posedge clk);
        rdc(OFS_INT_STATUS_0, 8'h00);
        wrr(OFS_AUX, 8'hf1); wrr(OFS_AUX, 8'hf0); repeat (30) @(posedge clk);
        rdc(OFS_INT_STATUS_0, 8'h00);
        // byte mode: data traffic restarts, flag then holds
        wrr(OFS_CFG, 8'h02); wrr(OFS_AUX, 8'hf1);
        for (int i = 0; i < 4; i++) begin
            repeat (10) @(posedge clk);
            if (i[0]) rdc(OFS_DATA, 8'h99);
            else wrr(OFS_DATA, 8'h11);
        end
        rdc(OFS_INT_STATUS_0, 8'h00);
        repeat (25) @(posedge clk);
        rdc(OFS_INT_STATUS_0, 8'h04); wrr(OFS_DATA, 8'h22);
        rdc(OFS_DATA, 8'h99); rdc(OFS_INT_STATUS_0, 8'h04);
        wrr(OFS_AUX, 8'hf0); rdc(OFS_INT_STATUS_0, 8'h00);
        // one-chip byte mode: bytes on the bus restart the count
        wrr(OFS_CFG, 8'h06); wrr(OFS_AUX, 8'hf1);
        repeat (4) begin
            repeat (10) @(posedge clk);
            st.byte_moved <= 1;
            @(posedge clk); st.byte_moved <= 0;
        end
        rdc(OFS_INT_STATUS_0, 8'h00);
        wrr(OFS_AUX, 8'hf0); wrr(OFS_CFG, 8'h00);
        // chip reset command stops a running timer
        wrr(OFS_AUX, 8'hf1); wrr(OFS_AUX, 8'h02);
        repeat (30) @(posedge clk);
        rdc(OFS_INT_STATUS_0, 8'h00);
        $display("test timer done");
        // bus lines: drive, plus another device asserting eoi and srq
        wrr(OFS_LINE, 8'h81); chk(oe, 8'h81);
        chk(line_v, 8'h00);
        ext <= 8'h0c; rdc(OFS_LINE, 8'h8d);
        ext <= 8'h00; wrr(OFS_LINE, 8'h00);
        $display("test lines done");
        // data-out latch is transparent during the write cycle
        addr <= OFS_DATA; wdata <= 8'h3c; wr <= 1;
        @(negedge clk); chk(dio, 8'h3c);
        @(posedge clk); wr <= 0; wdata <= 8'hc3;
        @(negedge clk); chk(dio, 8'h3c); chk({7'h00, nba}, 8'h01);
        chk({7'h00, dio_oe}, 8'h01);
        @(posedge clk);
        // static mode
        wrr(OFS_AUX, 8'he1);
        e = '0; e.err = 1; pulse(e);
        rdc(OFS_INT_STATUS_1, 8'h04); rdc(OFS_INT_STATUS_1, 8'h04);
        wrr(OFS_AUX, 8'h4a); rdc(OFS_INT_STATUS_1, 8'h00);
        e = '0; e.sync = 1; pulse(e);
        rdc(OFS_INT_STATUS_0, 8'h01); rdc(OFS_INT_STATUS_0, 8'h00);
        e = '0; e.address_pass_through_flag = 1; pulse(e);
        rdc(OFS_INT_STATUS_1, 8'h40); wrr(OFS_AUX, 8'h0f);
        rdc(OFS_INT_STATUS_1, 8'h00);
        cmd <= 8'h5a; e = '0; e.command_pass_through_flag = 1; pulse(e);
        rdc(OFS_INT_STATUS_1, 8'h80); rdc(OFS_PASS_THROUGH_COMMAND_REG, 8'h5a);
        rdc(OFS_INT_STATUS_1, 8'h00);
        e = '0; e.address_status_change_flag = 1; pulse(e);
        rdc(OFS_INT_STATUS_2, 8'h01); rdc(OFS_INT_STATUS_2, 8'h01);
        st.ton_lon <= 1;
        @(posedge clk); st.ton_lon <= 0;
        rdc(OFS_INT_STATUS_2, 8'h00);
        e = '0; e.data_out_rdy = 1; pulse(e);
        rdc(OFS_INT_STATUS_1, 8'h02); st.tacs <= 0;
        @(posedge clk); chk({7'h00, dio_oe}, 8'h00);
        rdc(OFS_INT_STATUS_1, 8'h00); st.tacs <= 1;
        e = '0; e.data_in = 1; pulse(e);
        rdc(OFS_INT_STATUS_1, 8'h01); rdc(OFS_DATA, 8'h99);
        rdc(OFS_INT_STATUS_1, 8'h00); chk(dio, 8'h3c);
        pulse(e); rdc(OFS_INT_STATUS_1, 8'h01);
        st.hs_done <= 1; st.holdoff <= 1;
        @(posedge clk); st.hs_done <= 0; st.holdoff <= 0;
        rdc(OFS_INT_STATUS_1, 8'h00);
        wrr(OFS_AUX, 8'he0);
        $display("test static mode done");
        // carry cycle, then reset keeps the command and stops the timer
        wrr(OFS_CCMD, 8'h5c); wrr(OFS_AUX, 8'hf1);
        for (int i = 0; i < 2; i++) begin
            wrr(OFS_CFG, 8'h01); st.last_byte <= 1;
            @(negedge clk); chk({7'h00, aux_exec}, 8'h01);
            chk(aux_code, 8'h5c);
            @(posedge clk); st.last_byte <= 0;
            if (i == 0) begin
                rst <= 1;
                repeat (2) @(posedge clk);
                rst <= 0;
                @(posedge clk);
            end
        end
        // one-chip mode ignores the carry command
        wrr(OFS_CFG, 8'h05); st.last_byte <= 1;
        @(negedge clk); chk({7'h00, aux_exec}, 8'h00);
        @(posedge clk); st.last_byte <= 0;
        wrr(OFS_CFG, 8'h00);
        repeat (30) @(posedge clk);
        rdc(OFS_INT_STATUS_0, 8'h00);
        $display("test carry and reset done");
        finish_test();
    end
endmodule
